//--- src/msc_regs.svh
// timing and reset constants for the module system controller
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH
`define MSC_CLK_PERIOD_NS 10
`define MSC_SUPPLY_SETTLE_US 100
`define MSC_SUPPLY_SETTLE_CYC \
    ((`MSC_SUPPLY_SETTLE_US * 1000 + `MSC_CLK_PERIOD_NS - 1) / \
    `MSC_CLK_PERIOD_NS)
`define MSC_CNT_W 16
`define MSC_LED_GREEN 0
`define MSC_LED_RED 1
// red alone from reset until the controller reaches run
`define MSC_LED_RESET 2'h2
`endif

//--- src/msc_pkg.sv
// types for the module system controller
`default_nettype none
package msc_pkg;
    typedef enum logic [2:0] {
        MSC_WAIT_SUPPLY = 3'b001,
        MSC_SETTLE = 3'b010,
        MSC_RUN = 3'b100
    } msc_state_t;
endpackage
`default_nettype wire

//--- src/msc_sync.sv
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
`default_nettype none
module msc_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic async_i,
    output logic sync_o
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_sync;

    always_comb begin
        next_stage = {stage[1:0], async_i};
        // first stage only feeds the second
        next_sync = (stage[1] == stage[2]) ? stage[2] : sync_o;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            stage <= {3{RESET_VALUE}};
            sync_o <= RESET_VALUE;
        end else begin
            stage <= next_stage;
            sync_o <= next_sync;
        end
    end
endmodule
`default_nettype wire

//--- src/msc_top.sv
// module system controller: configuration, reset, jtag and led steering
`timescale 1ns/1ns
`default_nettype none
`include "msc_regs.svh"
module msc_top
    import msc_pkg::*;
#(
    parameter int SETTLE_CYC = `MSC_SUPPLY_SETTLE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic supplies_ok_i,
    input wire logic power_enable_in_i,
    input wire logic external_reset_n_i,
    input wire logic jtag_target_select_i,
    input wire logic fpga_config_done_i,
    input wire logic [1:0] user_led_i,
    input wire logic jtag_tck_i,
    input wire logic jtag_tms_i,
    input wire logic jtag_tdi_i,
    output logic jtag_tdo_o,
    output logic fpga_tck_o,
    output logic fpga_tms_o,
    output logic fpga_tdi_o,
    input wire logic fpga_tdo_i,
    output logic ctrl_tck_o,
    output logic ctrl_tms_o,
    output logic ctrl_tdi_o,
    input wire logic ctrl_tdo_i,
    output logic power_good_out_o,
    output logic fpga_program_n_o,
    output logic fpga_por_n_o,
    output logic dcdc_enable_o,
    output logic green_status_led_o,
    output logic red_status_led_o
);
    logic supplies_ok;
    logic power_enable_in;
    logic external_reset_n;
    logic config_done;
    logic jtag_sel;
    logic user_green;
    logic user_red;
    msc_state_t state;
    msc_state_t next_state;
    logic [`MSC_CNT_W-1:0] settle_cnt;
    logic [`MSC_CNT_W-1:0] next_settle_cnt;
    logic next_power_good;
    logic next_program_n;
    logic next_por_n;
    logic [1:0] next_led;
    logic [1:0] led;

    // run state is decoded for several outputs
    function automatic logic in_run(input msc_state_t s);
        return s == MSC_RUN;
    endfunction

    // pin inputs other than the jtag lines pass three flops and the filter flop before anything looks at them
    msc_sync #(
        .RESET_VALUE(1'b0)
    ) u_sync_supply (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(supplies_ok_i),
        .sync_o(supplies_ok)
    );

    msc_sync #(
        .RESET_VALUE(1'b1)
    ) u_sync_en (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(power_enable_in_i),
        .sync_o(power_enable_in)
    );

    msc_sync #(
        .RESET_VALUE(1'b1)
    ) u_sync_rst (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(external_reset_n_i),
        .sync_o(external_reset_n)
    );

    msc_sync #(
        .RESET_VALUE(1'b0)
    ) u_sync_done (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(fpga_config_done_i),
        .sync_o(config_done)
    );

    msc_sync #(
        .RESET_VALUE(1'b0)
    ) u_sync_jtag (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(jtag_target_select_i),
        .sync_o(jtag_sel)
    );

    // user leds run on the fpga's clock, so they cross like any pin;
    // this costs a few cycles of led latency, which nobody can see
    msc_sync #(
        .RESET_VALUE(1'b0)
    ) u_sync_led_green (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(user_led_i[`MSC_LED_GREEN]),
        .sync_o(user_green)
    );

    msc_sync #(
        .RESET_VALUE(1'b0)
    ) u_sync_led_red (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(user_led_i[`MSC_LED_RED]),
        .sync_o(user_red)
    );

    // supply sequencing: count a settle time once supplies report ok
    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        case (state)
            MSC_WAIT_SUPPLY: begin
                next_settle_cnt = '0;
                if (supplies_ok) begin
                    next_state = MSC_SETTLE;
                end
            end
            MSC_SETTLE: begin
                if (!supplies_ok) begin
                    next_state = MSC_WAIT_SUPPLY;
                end else if (settle_cnt >= `MSC_CNT_W'(SETTLE_CYC - 1)) begin
                    next_state = MSC_RUN;
                end else begin
                    next_settle_cnt = settle_cnt + `MSC_CNT_W'(1);
                end
            end
            MSC_RUN: begin
                if (!supplies_ok) begin
                    next_state = MSC_WAIT_SUPPLY;
                end
            end
            default: begin
                next_state = MSC_WAIT_SUPPLY;
            end
        endcase
    end

    always_comb begin
        // power good also drops with enable so the baseboard tristates
        next_power_good = in_run(state) && power_enable_in;
        next_program_n = in_run(state);
        // enable low looks like a power-on reset; external reset the same
        next_por_n = power_enable_in && external_reset_n;
        if (config_done && in_run(state)) begin
            next_led[`MSC_LED_GREEN] = user_green;
            next_led[`MSC_LED_RED] = user_red;
        end else begin
            // controller shows sequencing: red while unconfigured
            next_led[`MSC_LED_GREEN] = in_run(state);
            next_led[`MSC_LED_RED] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state <= MSC_WAIT_SUPPLY;
            settle_cnt <= '0;
            power_good_out_o <= 1'b0;
            fpga_program_n_o <= 1'b0;
            fpga_por_n_o <= 1'b0;
            led <= `MSC_LED_RESET;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            power_good_out_o <= next_power_good;
            fpga_program_n_o <= next_program_n;
            fpga_por_n_o <= next_por_n;
            led <= next_led;
        end
    end

    assign green_status_led_o = led[`MSC_LED_GREEN];
    assign red_status_led_o = led[`MSC_LED_RED];
    // enable never reaches the converters; they stay on
    assign dcdc_enable_o = 1'b1;

    // jtag steering is combinational so tck is not resampled
    always_comb begin
        fpga_tck_o = 1'b0;
        fpga_tms_o = 1'b1;
        fpga_tdi_o = 1'b1;
        ctrl_tck_o = 1'b0;
        ctrl_tms_o = 1'b1;
        ctrl_tdi_o = 1'b1;
        if (jtag_sel) begin
            ctrl_tck_o = jtag_tck_i;
            ctrl_tms_o = jtag_tms_i;
            ctrl_tdi_o = jtag_tdi_i;
            jtag_tdo_o = ctrl_tdo_i;
        end else begin
            fpga_tck_o = jtag_tck_i;
            fpga_tms_o = jtag_tms_i;
            fpga_tdi_o = jtag_tdi_i;
            jtag_tdo_o = fpga_tdo_i;
        end
    end
endmodule
`default_nettype wire

//--- verification/msc_partner.sv
// fpga model: configures once program is released, echoes tdi inverted
`timescale 1ns/1ns
`default_nettype none
module msc_partner (
    input wire logic clk_i,
    input wire logic program_n_i,
    input wire logic tdi_i,
    output logic done_o,
    output logic tdo_o
);
    logic [2:0] cnt = 3'h0;
    // configuration restarts whenever program is pulled low
    always_ff @(posedge clk_i) begin
        cnt <= !program_n_i ? 3'h0 : cnt + {2'h0, cnt != 3'h7};
    end
    assign done_o = cnt == 3'h7;
    assign tdo_o = ~tdi_i;
endmodule
`default_nettype wire

//--- verification/msc_top_asserts.sv
// port assertions for the module system controller
`timescale 1ns/1ns
`default_nettype none
module msc_checker #(
    parameter int SETTLE_CYC = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic supplies_ok_i,
    input wire logic power_enable_in_i,
    input wire logic external_reset_n_i,
    input wire logic jtag_target_select_i,
    input wire logic fpga_config_done_i,
    input wire logic [1:0] user_led_i,
    input wire logic jtag_tck_i,
    input wire logic fpga_tck_o,
    input wire logic ctrl_tck_o,
    input wire logic power_good_out_o,
    input wire logic fpga_program_n_o,
    input wire logic fpga_por_n_o,
    input wire logic dcdc_enable_o,
    input wire logic green_status_led_o,
    input wire logic red_status_led_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [15:0] ok_cnt;
    // seven cycles leave room for the synchroniser and, on registered outputs, the output flop
    sequence sel_held(logic s);
        (jtag_target_select_i == s) [*7];
    endsequence
    sequence supply_low;
        !supplies_ok_i [*7];
    endsequence
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i || !supplies_ok_i) ok_cnt <= 16'h0;
        else if (ok_cnt != 16'hffff) ok_cnt <= ok_cnt + 16'h1;
    end
    jtag_fpga_a: assert property (sel_held(0) |->
        fpga_tck_o == jtag_tck_i && !ctrl_tck_o) else $error("jtag fpga");
    jtag_ctrl_a: assert property (sel_held(1) |->
        ctrl_tck_o == jtag_tck_i && !fpga_tck_o) else $error("jtag ctrl");
    good_enable_a: assert property (!power_enable_in_i [*7] |->
        !power_good_out_o) else $error("good with enable low");
    good_supply_a: assert property (supply_low |->
        !power_good_out_o) else $error("good with supply low");
    por_enable_a: assert property (!power_enable_in_i [*7] |->
        !fpga_por_n_o) else $error("por not low");
    prog_supply_a: assert property (supply_low |->
        !fpga_program_n_o) else $error("program not held");
    settle_wait_a: assert property ($rose(fpga_program_n_o) |->
        ok_cnt >= SETTLE_CYC) else $error("program released early");
    por_extrst_a: assert property (!external_reset_n_i [*7] |->
        !fpga_por_n_o) else $error("ext reset ignored");
    dcdc_on_a: assert property (dcdc_enable_o)
        else $error("converters off");
    led_pass_a: assert property ((fpga_config_done_i && fpga_por_n_o
        && fpga_program_n_o && $stable(user_led_i)) [*8] |->
        {red_status_led_o, green_status_led_o} == user_led_i)
        else $error("leds not passed");
endmodule
bind msc_top msc_checker #(.SETTLE_CYC(SETTLE_CYC)) u_msc_checker (.*);
`default_nettype wire

//--- verification/module_system_controller_bench.sv
// bench for the module system controller
`timescale 1ns/1ns
`default_nettype none
module module_system_controller_bench;
    logic sys_clk_i = 0, reset_n_i = 0, supplies_ok_i = 0;
    logic power_enable_in_i = 1, external_reset_n_i = 1;
    logic jtag_target_select_i = 0, jtag_tck_i = 0, jtag_tms_i = 1;
    logic jtag_tdi_i = 0, ctrl_tdo_i = 0;
    logic [1:0] user_led_i = 2'h0;
    logic fpga_config_done_i, fpga_tdo_i, jtag_tdo_o, fpga_tck_o;
    logic fpga_tms_o, fpga_tdi_o, ctrl_tck_o, ctrl_tms_o, ctrl_tdi_o;
    logic power_good_out_o, fpga_program_n_o, fpga_por_n_o;
    logic dcdc_enable_o, green_status_led_o, red_status_led_o;
    int n_mismatch = 0, cmp_count = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    msc_top #(.SETTLE_CYC(8)) u_msc_top (.*);
    msc_partner u_msc_partner (.clk_i(sys_clk_i),
        .program_n_i(fpga_program_n_o), .tdi_i(fpga_tdi_o),
        .done_o(fpga_config_done_i), .tdo_o(fpga_tdo_i));
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_powerup;
        supplies_ok_i = 1;
        cyc(8);
        chk({fpga_program_n_o, power_good_out_o}, 4'h0);
        chk({red_status_led_o, green_status_led_o}, 4'h2);
        cyc(12);
        chk({fpga_program_n_o, power_good_out_o, fpga_por_n_o}, 4'h7);
    endtask
    // jtag is driven only once power good is up
    task automatic t_jtag;
        for (int s = 0; s < 2; s++) begin
            jtag_target_select_i = s[0];
            {jtag_tck_i, jtag_tms_i, jtag_tdi_i, ctrl_tdo_i} = 4'h8;
            cyc(8);
            chk({fpga_tck_o, fpga_tms_o, fpga_tdi_o}, s ? 4'h3 : 4'h4);
            chk({ctrl_tck_o, ctrl_tms_o, ctrl_tdi_o}, s ? 4'h4 : 4'h3);
            chk(jtag_tdo_o, s ? 4'h0 : 4'h1);
        end
        jtag_target_select_i = 0;
    endtask
    task automatic t_leds;
        cyc(10);
        for (int v = 0; v < 4; v++) begin
            user_led_i = v[1:0];
            cyc(6);
            chk({red_status_led_o, green_status_led_o}, v[3:0]);
        end
    endtask
    task automatic t_fpga_reset;
        logic [5:0] cs [3] = '{6'h1c, 6'h2e, 6'h0c};
        foreach (cs[i]) begin
            {power_enable_in_i, external_reset_n_i} = cs[i][5:4];
            cyc(8);
            chk({dcdc_enable_o, fpga_program_n_o,
                power_good_out_o, fpga_por_n_o}, cs[i][3:0]);
            {power_enable_in_i, external_reset_n_i} = 2'h3;
            cyc(8);
            chk({power_good_out_o, fpga_por_n_o}, 4'h3);
        end
    endtask
    // a one-cycle reset pulse must be filtered by the synchroniser
    task automatic t_glitch;
        external_reset_n_i = 0;
        cyc(1);
        external_reset_n_i = 1;
        repeat (6) begin
            cyc(1);
            chk(fpga_por_n_o, 4'h1);
        end
    endtask
    task automatic t_supply_drop;
        supplies_ok_i = 0;
        cyc(8);
        chk({fpga_program_n_o, power_good_out_o}, 4'h0);
    endtask
    initial begin
        cyc(6);
        reset_n_i = 1;
        cyc(4);
        t_powerup;
        t_jtag;
        t_leds;
        t_fpga_reset;
        t_glitch;
        t_supply_drop;
        results;
    end
    // the sequence needs 143 cycles
    initial begin
        #20000;
        n_mismatch++;
        results;
    end
endmodule
`default_nettype wire
